// *** src/dcso_top.v ***
// Drive control and status register bank on AHB-Lite
//
// Local design decision: the AHB-Lite slave port.
`include "dcso_consts.vh"
`default_nettype none
module dcso_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [15:0] boot_major,
    input  wire [15:0] boot_minor,
    input  wire [31:0] boot_fieldbus_mask,
    input  wire        err_push,
    input  wire [31:0] err_entry,
    input  wire        fault_active,
    input  wire        reaction_done,
    input  wire        warning_in,
    input  wire        fieldbus_sync,
    input  wire        target_reached,
    input  wire        limit_active,
    input  wire        closed_loop,
    output reg         halt_request,
    output reg  [3:0]  mode_specific_bits,
    output reg  [7:0]  active_mode,
    output reg  [7:0]  power_state
);
    // Byte addresses derived from object indices
    localparam [31:0] A_BOOT_VER   = {14'h0000, `DCSO_IDX_BOOT_VER, 2'b00};
    localparam [31:0] A_BOOT_BUS   = {14'h0000, `DCSO_IDX_BOOT_BUS, 2'b00};
    localparam [31:0] A_ERR_CODE   = {14'h0000, `DCSO_IDX_ERR_CODE, 2'b00};
    localparam [31:0] A_CMD_WORD   = {14'h0000, `DCSO_IDX_CMD_WORD, 2'b00};
    localparam [31:0] A_STATE_WORD = {14'h0000, `DCSO_IDX_STATE_WORD, 2'b00};
    localparam [31:0] A_MODE_SEL   = {14'h0000, `DCSO_IDX_MODE_SEL, 2'b00};

    reg [15:0] cmd_reg;
    reg [15:0] err_reg;
    reg [7:0]  mode_reg;
    reg [15:0] state_word_reg;
    reg        wr_pend_reg;
    reg [31:0] wr_addr_reg;
    reg [31:0] rdata_next;
    reg [15:0] state_word_next;
    wire [7:0] fsm_state;
    wire       sync_s;
    wire       warn_s;
    wire       tgt_s;
    wire       lim_s;
    wire       cl_s;
    wire       fault_s;
    wire       react_s;

    // External levels cross in through two flops each
    dcso_sync2 u_sync_fb (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .d_async(fieldbus_sync), .q_sync(sync_s));
    dcso_sync2 u_sync_wn (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .d_async(warning_in), .q_sync(warn_s));
    dcso_sync2 u_sync_tg (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .d_async(target_reached), .q_sync(tgt_s));
    dcso_sync2 u_sync_lm (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .d_async(limit_active), .q_sync(lim_s));
    dcso_sync2 u_sync_cl (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .d_async(closed_loop), .q_sync(cl_s));
    dcso_sync2 u_sync_fa (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .d_async(fault_active), .q_sync(fault_s));
    dcso_sync2 u_sync_rd (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .d_async(reaction_done), .q_sync(react_s));

    dcso_power_fsm u_fsm (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .ce           (ce),
        .cmd_word     (cmd_reg),
        .fault_event  (err_push),
        .fault_active (fault_s),
        .reaction_done(react_s),
        .state_reg    (fsm_state)
    );

    // Address phase capture for writes; reads answer in their data phase
    wire addr_ok = hsel && htrans[1] && hready;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h00000000;
        end else if (ce) begin
            wr_pend_reg <= addr_ok && hwrite;
            if (addr_ok) wr_addr_reg <= haddr;
        end
    end

    // Read data mux; unmapped reads return zero
    always @* begin
        rdata_next = 32'h00000000;
        case (haddr)
            A_BOOT_VER:   rdata_next = {boot_major, boot_minor};
            A_BOOT_BUS:   rdata_next = boot_fieldbus_mask;
            A_ERR_CODE:   rdata_next = {16'h0000, err_reg};
            A_CMD_WORD:   rdata_next = {16'h0000, cmd_reg};
            A_STATE_WORD: rdata_next = {16'h0000, state_word_reg};
            A_MODE_SEL:   rdata_next = {24'h000000, mode_reg};
            default:      rdata_next = 32'h00000000;
        endcase
    end

    // Bus response: zero wait, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite) hrdata <= rdata_next;
        end
    end

    // Writable registers; read-only addresses ignore writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_reg  <= `DCSO_CMD_RESET;
            mode_reg <= `DCSO_MODE_RESET;
        end else if (ce && wr_pend_reg) begin
            if (wr_addr_reg == A_CMD_WORD) cmd_reg <= hwdata[15:0];
            if (wr_addr_reg == A_MODE_SEL) mode_reg <= hwdata[7:0];
        end
    end

    // Newest error history entry, low half kept
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) err_reg <= `DCSO_ERR_RESET;
        else if (ce && err_push) err_reg <= err_entry[15:0];
    end

    // State word assembly from power state and status levels
    always @* begin
        state_word_next = 16'h0000;
        case (fsm_state)
            `DCSO_PS_SOD:         state_word_next[6:0] = 7'h40;
            `DCSO_PS_READY:       state_word_next[6:0] = 7'h21;
            `DCSO_PS_SWITCHED_ON: state_word_next[6:0] = 7'h23;
            `DCSO_PS_OP_ENABLED:  state_word_next[6:0] = 7'h27;
            `DCSO_PS_QUICK_STOP:  state_word_next[6:0] = 7'h07;
            `DCSO_PS_FAULT_REACT: state_word_next[6:0] = 7'h0F;
            `DCSO_PS_FAULT:       state_word_next[6:0] = 7'h08;
            default:              state_word_next[6:0] = 7'h00;
        endcase
        state_word_next[`DCSO_ST_VOLTAGE] = cmd_reg[`DCSO_CMD_VOLTAGE] &&
            (fsm_state != `DCSO_PS_NOT_READY);
        state_word_next[`DCSO_ST_WARN]    = warn_s;
        state_word_next[`DCSO_ST_SYNC]    = sync_s;
        state_word_next[`DCSO_ST_REMOTE]  = 1'b1;
        state_word_next[`DCSO_ST_HALTED]  = tgt_s;
        state_word_next[11]               = lim_s;
        state_word_next[`DCSO_ST_CLOSED_LOOP] = cl_s &&
            (fsm_state == `DCSO_PS_OP_ENABLED);
    end

    // Halt only valid in halt-capable modes
    wire halt_mode = (mode_reg == `DCSO_MODE_PROF_POS) ||
                     (mode_reg == `DCSO_MODE_VELOCITY) ||
                     (mode_reg == `DCSO_MODE_PROF_VEL) ||
                     (mode_reg == `DCSO_MODE_PROF_TRQ) ||
                     (mode_reg == `DCSO_MODE_INTERP);

    // Registered outputs toward drive logic; state word zero during reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_word_reg     <= 16'h0000;
            halt_request       <= 1'b0;
            mode_specific_bits <= 4'h0;
            active_mode        <= 8'h00;
            power_state        <= `DCSO_PS_NOT_READY;
        end else if (ce) begin
            state_word_reg     <= state_word_next;
            halt_request       <= cmd_reg[`DCSO_CMD_HALT] && halt_mode;
            // Passed with the mode so drive logic decodes per mode
            mode_specific_bits <= {cmd_reg[`DCSO_CMD_MODE_BIT9], cmd_reg[6:4]};
            active_mode        <= mode_reg;
            power_state        <= fsm_state;
        end
    end
endmodule // dcso_top
`default_nettype wire

// *** src/dcso_consts.vh ***
// Constants of the drive control and status register block
`ifndef DCSO_CONSTS_VH
`define DCSO_CONSTS_VH
// Object indices; byte address is four times the index
`define DCSO_IDX_BOOT_VER   16'h4042
`define DCSO_IDX_BOOT_BUS   16'h4043
`define DCSO_IDX_ERR_CODE   16'h603F
`define DCSO_IDX_CMD_WORD   16'h6040
`define DCSO_IDX_STATE_WORD 16'h6041
`define DCSO_IDX_MODE_SEL   16'h6060
`define DCSO_IDX_PLANT      16'h6061
// Command word fields
`define DCSO_CMD_SWITCH_ON  0
`define DCSO_CMD_VOLTAGE    1
`define DCSO_CMD_QSTOP_N    2
`define DCSO_CMD_OPERATION  3
`define DCSO_CMD_FAULT_CLR  7
`define DCSO_CMD_HALT       8
`define DCSO_CMD_MODE_BIT9  9
// State word fields
`define DCSO_ST_FAULT       3
`define DCSO_ST_VOLTAGE     4
`define DCSO_ST_QSTOP       5
`define DCSO_ST_SOD         6
`define DCSO_ST_WARN        7
`define DCSO_ST_SYNC        8
`define DCSO_ST_REMOTE      9
`define DCSO_ST_HALTED      10
`define DCSO_ST_MODE_LO     12
`define DCSO_ST_MODE_HI     13
`define DCSO_ST_CLOSED_LOOP 15
// Reset values
`define DCSO_CMD_RESET      16'h0000
`define DCSO_ERR_RESET      16'h0000
`define DCSO_MODE_RESET     8'h00
// Operating mode codes
`define DCSO_MODE_PROF_POS  8'h01
`define DCSO_MODE_VELOCITY  8'h02
`define DCSO_MODE_PROF_VEL  8'h03
`define DCSO_MODE_PROF_TRQ  8'h04
`define DCSO_MODE_INTERP    8'h07
// One-hot power states
`define DCSO_PS_NOT_READY   8'h01
`define DCSO_PS_SOD         8'h02
`define DCSO_PS_READY       8'h04
`define DCSO_PS_SWITCHED_ON 8'h08
`define DCSO_PS_OP_ENABLED  8'h10
`define DCSO_PS_QUICK_STOP  8'h20
`define DCSO_PS_FAULT_REACT 8'h40
`define DCSO_PS_FAULT       8'h80
`endif

// *** src/dcso_sync2.v ***
// Two-flop synchroniser for one level from outside the clock domain
`default_nettype none
module dcso_sync2 (
    input  wire hclk,
    input  wire hresetn,
    input  wire ce,
    input  wire d_async,
    output wire q_sync
);
    reg meta_reg;
    reg sync_reg;

    // First flop feeds only the second
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else if (ce) begin
            meta_reg <= d_async;
            sync_reg <= meta_reg;
        end
    end
    assign q_sync = sync_reg;
endmodule // dcso_sync2
`default_nettype wire

// *** src/dcso_power_fsm.v ***
// Power state machine driven by the command word
`include "dcso_consts.vh"
`default_nettype none
module dcso_power_fsm (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire [15:0] cmd_word,
    input  wire        fault_event,
    input  wire        fault_active,
    input  wire        reaction_done,
    output reg  [7:0]  state_reg
);
    localparam [7:0] NOT_READY = `DCSO_PS_NOT_READY;
    localparam [7:0] SOD       = `DCSO_PS_SOD;
    localparam [7:0] READY     = `DCSO_PS_READY;
    localparam [7:0] SW_ON     = `DCSO_PS_SWITCHED_ON;
    localparam [7:0] OP_EN     = `DCSO_PS_OP_ENABLED;
    localparam [7:0] QSTOP     = `DCSO_PS_QUICK_STOP;
    localparam [7:0] F_REACT   = `DCSO_PS_FAULT_REACT;
    localparam [7:0] FAULT     = `DCSO_PS_FAULT;

    reg [7:0] state_next;
    wire so = cmd_word[`DCSO_CMD_SWITCH_ON];
    wire ev = cmd_word[`DCSO_CMD_VOLTAGE];
    wire qs_n = cmd_word[`DCSO_CMD_QSTOP_N];
    wire eo = cmd_word[`DCSO_CMD_OPERATION];
    wire fr = cmd_word[`DCSO_CMD_FAULT_CLR];

    // Next state; a new fault overrides any command in every state but F_REACT and FAULT, where it is ignored
    always @* begin
        state_next = state_reg;
        if (fault_event && state_reg != FAULT && state_reg != F_REACT) begin
            state_next = F_REACT;
        end else begin
            case (state_reg)
                NOT_READY: state_next = SOD;
                SOD: if (ev && qs_n) state_next = READY;
                READY: begin
                    if (!ev || !qs_n) state_next = SOD;
                    else if (so) state_next = SW_ON;
                end
                SW_ON: begin
                    if (!ev || !qs_n) state_next = SOD;
                    else if (!so) state_next = READY;
                    else if (eo) state_next = OP_EN;
                end
                OP_EN: begin
                    if (!ev) state_next = SOD;
                    else if (!qs_n) state_next = QSTOP;
                    else if (!so) state_next = READY;
                    else if (!eo) state_next = SW_ON;
                end
                QSTOP: if (!ev) state_next = SOD;
                F_REACT: if (reaction_done) state_next = FAULT;
                // Clear only once the fault source is gone
                FAULT: if (fr && !fault_active) state_next = SOD;
                default: state_next = NOT_READY;
            endcase
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) state_reg <= NOT_READY;
        else if (ce) state_reg <= state_next;
    end
endmodule // dcso_power_fsm
`default_nettype wire

// *** bench/dcso_plant_model.sv ***
// Plant stand-in that raises an error entry and a fault on request
`default_nettype none
module dcso_plant_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        fault_cmd,
    output var  logic        err_push,
    output var  logic [31:0] err_entry,
    output var  logic        fault_active,
    output var  logic        reaction_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt_reg;
    // Fixed entry; only its low half reaches the error code
    assign err_entry = 32'hABCD1234;
    // One push per new fault, reaction ends some twenty cycles later
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_push <= 1'b0;
            fault_active <= 1'b0;
            reaction_done <= 1'b0;
            cnt_reg <= 5'h00;
        end else begin
            err_push <= fault_cmd && !fault_active;
            fault_active <= fault_cmd;
            cnt_reg <= fault_cmd ? cnt_reg + {4'h0, cnt_reg != 5'h1F} : 5'h00;
            reaction_done <= fault_cmd && (cnt_reg > 5'h13);
        end
    end
endmodule // dcso_plant_model
`default_nettype wire

// *** bench/dcso_top_monitor.sv ***
// Port-level checks of the drive control and status register bank
`include "dcso_consts.vh"
`default_nettype none
module dcso_top_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic [15:0] boot_major,
    input wire logic [15:0] boot_minor,
    input wire logic [31:0] boot_fieldbus_mask,
    input wire logic        err_push,
    input wire logic        reaction_done,
    input wire logic        halt_request,
    input wire logic [7:0]  active_mode,
    input wire logic [7:0]  power_state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Read taken this edge; data stands after it
    wire rd_x = hsel && htrans[1] && hready && !hwrite;
    a_boot_version: assert property (rd_x && haddr == `DCSO_IDX_BOOT_VER * 4
        |=> hrdata == {$past(boot_major), $past(boot_minor)}) else $error("boot version");
    a_boot_fieldbus: assert property (rd_x && haddr == `DCSO_IDX_BOOT_BUS * 4
        |=> hrdata == $past(boot_fieldbus_mask)) else $error("boot fieldbus mask");
    a_err_width: assert property (rd_x && haddr == `DCSO_IDX_ERR_CODE * 4
        |=> hrdata[31:16] == 16'h0000) else $error("error code wider than 16 bits");
    a_state_remote: assert property (rd_x && haddr == `DCSO_IDX_STATE_WORD * 4
        |=> hrdata[31:16] == 16'h0000 && hrdata[9]) else $error("state word remote bit");
    // Halt and active_mode update on the same edge; only stable modes are checked
    a_halt_modes: assert property (halt_request && $stable(active_mode)
        |-> active_mode inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h07}) else $error("halt mode");
    a_power_onehot: assert property ($onehot(power_state)) else $error("power state");
    a_fault_enter: assert property (err_push && power_state != 8'h80
        |-> ##[1:4] power_state == 8'h40) else $error("no fault reaction");
    a_fault_settle: assert property (power_state == 8'h40 && reaction_done
        |-> ##[1:5] power_state == 8'h80) else $error("no fault state");
    c_op_enabled: cover property (power_state == 8'h10);
    c_quick_stop: cover property (power_state == 8'h20);
    c_halt: cover property (halt_request);
endmodule // dcso_top_monitor
bind dcso_top dcso_top_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .boot_major(boot_major), .boot_minor(boot_minor), .boot_fieldbus_mask(boot_fieldbus_mask),
    .err_push(err_push), .reaction_done(reaction_done), .halt_request(halt_request),
    .active_mode(active_mode), .power_state(power_state));
`default_nettype wire

// *** bench/dcso_top_bench.sv ***
// Self-checking bench for the drive control and status register bank
`include "dcso_consts.vh"
`default_nettype none
module dcso_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] A_VER = `DCSO_IDX_BOOT_VER * 4;
    localparam logic [31:0] A_BUS = `DCSO_IDX_BOOT_BUS * 4;
    localparam logic [31:0] A_ERR = `DCSO_IDX_ERR_CODE * 4;
    localparam logic [31:0] A_CMD = `DCSO_IDX_CMD_WORD * 4;
    localparam logic [31:0] A_ST  = `DCSO_IDX_STATE_WORD * 4;
    localparam logic [31:0] A_MOD = `DCSO_IDX_MODE_SEL * 4;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        fault_cmd = 1'b0;
    logic        sync_in = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    wire  [31:0] hrdata, err_entry;
    wire  [7:0]  active_mode, power_state;
    wire  [3:0]  msb;
    wire         hreadyout, hresp, err_push, fault_active, reaction_done, halt_request;
    int          errors = 0;
    int          checks = 0;
    logic [15:0] cmds [5] = '{16'h0006, 16'h0007, 16'h000F, 16'h000B, 16'h0000};
    logic [15:0] sts [5] = '{16'h0221, 16'h0223, 16'h0227, 16'h0207, 16'h0240};
    logic [7:0]  modes [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h05, 8'h00};
    dcso_top u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .boot_major(16'h0004),
        .boot_minor(16'h0002), .boot_fieldbus_mask(32'h00000005), .err_push(err_push),
        .err_entry(err_entry), .fault_active(fault_active), .reaction_done(reaction_done),
        .warning_in(sync_in), .fieldbus_sync(sync_in), .target_reached(sync_in),
        .limit_active(sync_in), .closed_loop(sync_in), .halt_request(halt_request),
        .mode_specific_bits(msb), .active_mode(active_mode), .power_state(power_state));
    dcso_plant_model u_plant (.hclk(hclk), .hresetn(hresetn), .fault_cmd(fault_cmd),
        .err_push(err_push), .err_entry(err_entry), .fault_active(fault_active),
        .reaction_done(reaction_done));
    always #25 hclk = ~hclk;
    task automatic summarize;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                errors++;
                summarize();
            end
            @(posedge hclk);
        end
    endtask
    // One single AHB-Lite transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e);
        chk({31'h0, hresp}, 32'h0); // Response must stay OKAY
    endtask
    // Bit 5 only matters in the three running states and quick stop
    task automatic stp(input logic [15:0] c, input logic [15:0] e);
        bus(1'b1, A_CMD, {16'h0, c});
        repeat (4) @(posedge hclk);
        rdchk(A_ST, (e[0] && !e[3]) ? 32'hFFFF026F : 32'hFFFF024F, {16'h0, e});
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        rdchk(A_ST, 32'hFFFF024F, 32'h00000240);
        rdchk(A_CMD, 32'hFFFFFFFF, 32'h0);
        rdchk(A_ERR, 32'hFFFFFFFF, 32'h0);
        $display("test reset done");
        bus(1'b1, A_VER, 32'h0);
        bus(1'b1, A_ERR, 32'h0000FFFF);
        rdchk(A_VER, 32'hFFFFFFFF, 32'h00040002);
        rdchk(A_ERR, 32'hFFFFFFFF, 32'h0);
        rdchk(A_BUS, 32'hFFFFFFFF, 32'h00000005);
        rdchk(32'h00020000, 32'hFFFFFFFF, 32'h0);
        $display("test boot done");
        foreach (cmds[i]) stp(cmds[i], sts[i]);
        $display("test power done");
        foreach (modes[i]) begin
            bus(1'b1, A_MOD, {24'h0, modes[i]});
            stp(16'h0370, 16'h0240);
            chk({31'h0, halt_request}, {31'h0, i < 5});
            chk({28'h0, msb}, 32'h0000000F);
            chk({24'h0, active_mode}, {24'h0, modes[i]});
            rdchk(A_MOD, 32'hFFFFFFFF, {24'h0, modes[i]});
            rdchk(A_CMD, 32'hFFFFFFFF, 32'h00000370);
        end
        stp(16'h0000, 16'h0240);
        $display("test halt done");
        fault_cmd <= 1'b1;
        repeat (6) @(posedge hclk);
        rdchk(A_ST, 32'hFFFF024F, 32'h0000020F);
        repeat (30) @(posedge hclk);
        rdchk(A_ST, 32'hFFFF024F, 32'h00000208);
        chk({24'h0, power_state}, 32'h00000080);
        rdchk(A_ERR, 32'hFFFFFFFF, 32'h00001234);
        stp(16'h0080, 16'h0208);
        fault_cmd <= 1'b0;
        stp(16'h0000, 16'h0208);
        stp(16'h0080, 16'h0240);
        $display("test fault done");
        // Enable low must freeze the synchronisers and the state word
        ce <= 1'b0;
        sync_in <= 1'b1;
        repeat (6) @(posedge hclk);
        ce <= 1'b1;
        rdchk(A_ST, 32'h00008D80, 32'h0);
        repeat (4) @(posedge hclk);
        rdchk(A_ST, 32'h00008D80, 32'h00000D80);
        sync_in <= 1'b0;
        repeat (4) @(posedge hclk);
        rdchk(A_ST, 32'h00008D80, 32'h0);
        $display("test sync done");
        summarize();
    end
endmodule // dcso_top_bench
`default_nettype wire
